// File: verilog/acad_pkg.sv
// Package for the address check and attribute decode block.
// Assumes a single core clock domain; shared by the block and its bench.
`default_nettype none
package acad_pkg;
    // Architectural address geometry.
    localparam int ACAD_ADDR_W     = 64;
    localparam int ACAD_PA_TOP     = 62;              // Highest physical bit.
    localparam int ACAD_PA_MIN_TOP = 31;              // Bits 0..31 always exist.
    localparam int ACAD_VA_TOP     = 60;              // Highest virtual bit.
    localparam int ACAD_VA_MIN_TOP = 50;
    localparam int ACAD_ATTR_BIT   = 63;              // Physical attribute bit.
    localparam int ACAD_RGN_LO     = 61;              // Region index 63:61.
    localparam int ACAD_BRK_MASK_W = 56;              // Breakpoint mask width.
    localparam logic [1:0] ACAD_OKAY   = 2'h0;
    localparam logic [1:0] ACAD_SLVERR = 2'h2;

    // Register byte offsets (word aligned).
    localparam logic [7:0] ACAD_REG_CTRL   = 8'h00;
    localparam logic [7:0] ACAD_REG_ADDR_L = 8'h04;
    localparam logic [7:0] ACAD_REG_ADDR_H = 8'h08;
    localparam logic [7:0] ACAD_REG_CMD    = 8'h0C;
    localparam logic [7:0] ACAD_REG_RES    = 8'h10;
    localparam logic [7:0] ACAD_REG_OUTL   = 8'h14;
    localparam logic [7:0] ACAD_REG_OUTH   = 8'h18;
    localparam logic [7:0] ACAD_REG_CFG    = 8'h1C;

    // Control register fields.
    localparam int ACAD_CTRL_IT = 0;
    localparam int ACAD_CTRL_DT = 1;
    localparam int ACAD_CTRL_RT = 2;
    localparam logic [2:0] ACAD_CTRL_RST = 3'h7;

    // Translation attribute codes.
    typedef enum logic [2:0] {
        ACAD_AC_WBACK   = 3'b000,
        ACAD_AC_SWRSV   = 3'b001,
        ACAD_AC_RSV2    = 3'b010,
        ACAD_AC_RSV3    = 3'b011,
        ACAD_AC_STRICT  = 3'b100,
        ACAD_AC_EXPORT  = 3'b101,
        ACAD_AC_COMBINE = 3'b110,
        ACAD_AC_NATPG   = 3'b111
    } acad_attr_code_t;

    // Operation classes checked by the block.
    typedef enum logic [3:0] {
        ACAD_OP_IFETCH   = 4'h0,  // Instruction fetch / last executed.
        ACAD_OP_BRANCH   = 4'h1,  // Taken or fall-through branch, or return.
        ACAD_OP_LOAD     = 4'h2,  // Non-speculative load, store, semaphore.
        ACAD_OP_NOACCESS = 4'h3,  // Flush, translate, faulting prefetch/probe.
        ACAD_OP_STK_MAND = 4'h4,  // Mandatory stack engine op.
        ACAD_OP_STK_EAGR = 4'h5,  // Eager stack engine op.
        ACAD_OP_SPEC_LD  = 4'h6,  // Speculative load.
        ACAD_OP_PROBE_NF = 4'h7,  // Non-faulting probe.
        ACAD_OP_KEYQ     = 4'h8,  // Key-access query.
        ACAD_OP_PREF_NF  = 4'h9,  // Non-faulting prefetch.
        ACAD_OP_INSERT   = 4'hA,  // Software TLB insert (fault addr + page).
        ACAD_OP_PURGE    = 4'hB,  // TLB purge (operand base).
        ACAD_OP_WALK_INS = 4'hC,  // Hardware walker insert.
        ACAD_OP_GPURGE_O = 4'hD,  // Outgoing global purge.
        ACAD_OP_GPURGE_I = 4'hE   // Incoming global purge.
    } acad_op_t;

    // Decoded memory properties.
    typedef struct packed {
        logic cacheable;
        logic writeback;
        logic coalescing;
        logic sequential;
        logic speculative;
        logic limited_spec;
        logic mp_coherent;
        logic invalid_token_page;
        logic exported;
        logic reserved;
    } acad_props_t;

    // Check outcome flags.
    typedef struct packed {
        logic instr_trap;
        logic data_fault;
        logic rsv_field_fault;
        logic walk_abort;
        logic dropped;
        logic token_bit;
        logic result_one;
        logic mcheck;
    } acad_result_t;
endpackage : acad_pkg
`default_nettype wire

// File: verilog/acad_core.sv
// Address check and attribute decode block with an AXI4-Lite register port.
// Assumes an AXI4-Lite master on aclk and a platform time-out pin from outside.
//
// Behaviour
// RULE_01: Memory and I/O share one 63-bit byte-addressed physical space.
// RULE_02: Physical addressing per class when its translate bit is zero.
// RULE_03: Physical address width is 32 to 63 bits, contiguous from bit 32.
// RULE_04: Instruction fetch to unimplemented physical address raises instruction trap.
// RULE_05: Data reference to unimplemented physical address raises data fault.
// RULE_06: Platform time-out on unpopulated range raises asynchronous machine check.
// RULE_07: Address registers keep all 64 bits; breakpoint mask holds 56 bits.
// RULE_08: Top physical bit position is a constant, 62 when fully implemented.
// RULE_09: Software insert with bad physical bits faults; walker insert aborts.
// RULE_10: Not-present translations skip page number validity checks.
// RULE_11: Physical address valid only when bits above top implemented are zero.
// RULE_12: Region index in bits 63:61; top virtual bit between 50 and 60.
// RULE_13: Virtual address valid only when upper bits sign-extend top bit.
// RULE_14: Non-speculative and mandatory references to bad address raise data fault.
// RULE_15: Purge and insert check only base address, ignoring page size.
// RULE_16: Non-faulting forms return token, zero or one, or drop silently.
// RULE_17: Branch, return or fetch to bad virtual address raises instruction trap.
// RULE_18: Outgoing purge sign-extends; incoming purge truncates unimplemented bits. The code truncates them only when they do not copy the top bit.
// RULE_19: Attribute codes 000, 110, 111 decode; 001, 010, 011 are reserved.
// RULE_20: Code 100 is uncached strict; 101 also exports atomic fetch-add.
// RULE_21: Insert with reserved attribute code raises reserved-field fault.
// RULE_22: Under physical addressing, attribute comes from address bit 63.
// RULE_23: Bit 63 is stripped; 0 gives limited write-back, 1 uncached strict.
`default_nettype none
module acad_core
    import acad_pkg::*;
#(
    parameter int TOP_PHYS_BIT_POS = 62,   // Implemented physical top bit.
    parameter int TOP_VIRT_BIT_POS = 60    // Implemented virtual top bit.
) (
    input  wire logic        aclk,            // Core clock.
    input  wire logic        aresetn,         // Synchronous reset, active low.
    input  wire logic [7:0]  s_axi_awaddr,    // Write address.
    input  wire logic        s_axi_awvalid,   // Write address valid.
    output logic             s_axi_awready,   // Write address ready.
    input  wire logic [31:0] s_axi_wdata,     // Write data.
    input  wire logic [3:0]  s_axi_wstrb,     // Write byte enables.
    input  wire logic        s_axi_wvalid,    // Write data valid.
    output logic             s_axi_wready,    // Write data ready.
    output logic [1:0]       s_axi_bresp,     // Write response.
    output logic             s_axi_bvalid,    // Write response valid.
    input  wire logic        s_axi_bready,    // Write response ready.
    input  wire logic [7:0]  s_axi_araddr,    // Read address.
    input  wire logic        s_axi_arvalid,   // Read address valid.
    output logic             s_axi_arready,   // Read address ready.
    output logic [31:0]      s_axi_rdata,     // Read data.
    output logic [1:0]       s_axi_rresp,     // Read response.
    output logic             s_axi_rvalid,    // Read data valid.
    input  wire logic        s_axi_rready,    // Read data ready.
    input  wire logic        platform_timeout,// Platform time-out pin.
    output logic             mcheck_abort     // Machine check abort level.
);
    ////////////////////////////////////////////////////////////////////////////
    // Implementation limits.
    localparam int PA_CHK_LO = (TOP_PHYS_BIT_POS + 1 < ACAD_PA_TOP)
                               ? TOP_PHYS_BIT_POS + 1 : ACAD_PA_TOP;  // [RULE_11]
    localparam int VA_CHK_LO = (TOP_VIRT_BIT_POS + 1 < ACAD_VA_TOP)
                               ? TOP_VIRT_BIT_POS + 1 : ACAD_VA_TOP;  // [RULE_13]

    // Physical address is implemented when bits 62..PA_CHK_LO are zero. [RULE_03]
    function automatic logic pa_ok(input logic [63:0] a);
        logic r;
        r = 1'b1;
        for (int i = PA_CHK_LO; i <= ACAD_PA_TOP; i++) begin
            if (i > TOP_PHYS_BIT_POS && a[i]) begin
                r = 1'b0;  // [RULE_11]
            end
        end
        return r;
    endfunction : pa_ok

    // Virtual address is implemented when 60..VA_CHK_LO copy the top bit.
    function automatic logic va_ok(input logic [63:0] a);
        logic r;
        r = 1'b1;
        for (int i = VA_CHK_LO; i <= ACAD_VA_TOP; i++) begin
            if (i > TOP_VIRT_BIT_POS && a[i] != a[TOP_VIRT_BIT_POS]) begin
                r = 1'b0;  // [RULE_13]
            end
        end
        return r;
    endfunction : va_ok

    // Attribute code to memory properties.
    function automatic acad_props_t decode_code(input logic [2:0] c);
        acad_props_t p;
        p = '0;
        unique case (acad_attr_code_t'(c))
            ACAD_AC_WBACK: begin  // [RULE_19]
                p.cacheable = 1'b1; p.writeback = 1'b1;
                p.speculative = 1'b1; p.mp_coherent = 1'b1;
            end
            ACAD_AC_COMBINE: begin  // [RULE_19]
                p.coalescing = 1'b1; p.speculative = 1'b1;
            end
            ACAD_AC_NATPG: begin  // [RULE_19]
                p.cacheable = 1'b1; p.speculative = 1'b1;
                p.invalid_token_page = 1'b1;
            end
            ACAD_AC_STRICT: begin  // [RULE_20]
                p.sequential = 1'b1; p.mp_coherent = 1'b1;
            end
            ACAD_AC_EXPORT: begin  // [RULE_20]
                p.sequential = 1'b1; p.mp_coherent = 1'b1; p.exported = 1'b1;
            end
            ACAD_AC_SWRSV, ACAD_AC_RSV2, ACAD_AC_RSV3: begin
                p.reserved = 1'b1;  // [RULE_19]
            end
        endcase
        return p;
    endfunction : decode_code

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [2:0]   xlate;        // Fetch, data and stack translate bits.
    logic [63:0]  req_addr;     // Address under check, all 64 bits kept. [RULE_07]
    logic [3:0]   req_op;
    logic [2:0]   req_code;
    logic         req_present;
    logic         req_start;
    acad_result_t res;
    acad_props_t  props;
    logic [63:0]  out_addr;
    logic         done;
    logic         to_s1;
    logic         to_s2;

    // Write channel: address and data are taken together in one cycle.
    logic wr_go;
    logic [31:0] wmask;
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    // Write handshake and response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ACAD_OKAY;
        end else begin
            s_axi_awready <= wr_go && !s_axi_awready;
            s_axi_wready  <= wr_go && !s_axi_awready;
            if (wr_go && !s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (s_axi_awaddr <= ACAD_REG_CMD) ? ACAD_OKAY : ACAD_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; a write to the command register starts a check.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xlate       <= ACAD_CTRL_RST;
            req_addr    <= '0;
            req_op      <= '0;
            req_code    <= '0;
            req_present <= 1'b0;
            req_start   <= 1'b0;
        end else begin
            req_start <= 1'b0;
            if (wr_go && !s_axi_awready) begin
                unique case (s_axi_awaddr)
                    ACAD_REG_CTRL:   xlate <= (xlate & ~wmask[2:0]) | (s_axi_wdata[2:0] & wmask[2:0]);
                    ACAD_REG_ADDR_L: req_addr[31:0] <= (req_addr[31:0] & ~wmask) | (s_axi_wdata & wmask);
                    ACAD_REG_ADDR_H: req_addr[63:32] <= (req_addr[63:32] & ~wmask) | (s_axi_wdata & wmask);
                    ACAD_REG_CMD: begin
                        req_op      <= s_axi_wdata[3:0];
                        req_code    <= s_axi_wdata[6:4];
                        req_present <= s_axi_wdata[7];
                        req_start   <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Check engine: one cycle after the command write the result is stored.
    logic phys_mode;
    logic pa_good;
    logic va_good;
    logic addr_good;
    logic [63:0] pa_stripped;
    logic [63:0] va_sext;
    logic [63:0] va_trunc;

    // Per-class physical mode selection.
    always_comb begin
        unique case (acad_op_t'(req_op))
            ACAD_OP_IFETCH, ACAD_OP_BRANCH: phys_mode = !xlate[ACAD_CTRL_IT];  // [RULE_02]
            ACAD_OP_STK_MAND, ACAD_OP_STK_EAGR: phys_mode = !xlate[ACAD_CTRL_RT];
            ACAD_OP_INSERT, ACAD_OP_PURGE, ACAD_OP_WALK_INS,
            ACAD_OP_GPURGE_O, ACAD_OP_GPURGE_I: phys_mode = 1'b0;
            default: phys_mode = !xlate[ACAD_CTRL_DT];
        endcase
    end

    // Physical address drops the attribute bit before checking. [RULE_23]
    assign pa_stripped = {1'b0, req_addr[ACAD_PA_TOP:0]};  // [RULE_01]
    assign pa_good     = pa_ok(pa_stripped);
    assign va_good     = va_ok(req_addr);  // [RULE_12]
    assign addr_good   = phys_mode ? pa_good : va_good;
    assign va_sext     = {{(ACAD_ADDR_W-TOP_VIRT_BIT_POS-1){req_addr[TOP_VIRT_BIT_POS]}},
                          req_addr[TOP_VIRT_BIT_POS:0]};
    assign va_trunc    = {req_addr[63:ACAD_RGN_LO],
                          {(ACAD_RGN_LO-TOP_VIRT_BIT_POS-1){1'b0}},
                          req_addr[TOP_VIRT_BIT_POS:0]};

    // Result computation per operation class.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res      <= '0;
            props    <= '0;
            out_addr <= '0;
            done     <= 1'b0;
        end else if (req_start) begin
            res      <= '0;
            done     <= 1'b1;
            out_addr <= phys_mode ? pa_stripped : req_addr;
            // Attribute comes from bit 63 in physical mode, else from the code.
            if (phys_mode) begin  // [RULE_22]
                props <= '0;
                if (req_addr[ACAD_ATTR_BIT]) begin
                    props.sequential <= 1'b1;  // [RULE_23]
                    props.mp_coherent <= 1'b1;
                end else begin
                    props.cacheable <= 1'b1;   // [RULE_23]
                    props.writeback <= 1'b1;
                    props.limited_spec <= 1'b1;
                    props.mp_coherent <= 1'b1;
                end
            end else begin
                props <= decode_code(req_code);
            end
            unique case (acad_op_t'(req_op))
                ACAD_OP_IFETCH, ACAD_OP_BRANCH:
                    res.instr_trap <= !addr_good;  // [RULE_04] [RULE_17]
                ACAD_OP_LOAD, ACAD_OP_NOACCESS, ACAD_OP_STK_MAND:
                    res.data_fault <= !addr_good;  // [RULE_05] [RULE_14]
                ACAD_OP_STK_EAGR:
                    res.dropped <= !addr_good;     // [RULE_16]
                ACAD_OP_SPEC_LD:
                    res.token_bit <= !addr_good;   // [RULE_16]
                ACAD_OP_PROBE_NF: begin
                    res.dropped <= !addr_good;     // [RULE_16]
                    if (!addr_good) out_addr <= '0;
                end
                ACAD_OP_KEYQ:
                    res.result_one <= !addr_good;  // [RULE_16]
                ACAD_OP_PREF_NF:
                    res.dropped <= !addr_good;     // [RULE_16]
                ACAD_OP_PURGE:
                    res.data_fault <= !va_good;    // [RULE_15]
                ACAD_OP_INSERT: begin
                    // Address register holds the fault address and is also checked as the page.
                    if (!va_good) res.data_fault <= 1'b1;  // [RULE_15]
                    else if (req_present && !pa_good) res.data_fault <= 1'b1;  // [RULE_09] [RULE_10]
                    else if (decode_code(req_code).reserved) res.rsv_field_fault <= 1'b1;  // [RULE_21]
                end
                ACAD_OP_WALK_INS:
                    res.walk_abort <= req_present && (!pa_good || decode_code(req_code).reserved);  // [RULE_09]
                ACAD_OP_GPURGE_O:
                    out_addr <= va_sext;           // [RULE_18]
                ACAD_OP_GPURGE_I:
                    out_addr <= va_good ? req_addr : va_trunc;  // [RULE_18]
                default: res.data_fault <= 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Platform time-out synchroniser and sticky machine check. Set wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            to_s1 <= 1'b0;
            to_s2 <= 1'b0;
            mcheck_abort <= 1'b0;
        end else begin
            to_s1 <= platform_timeout;
            to_s2 <= to_s1;
            if (to_s2) mcheck_abort <= 1'b1;  // [RULE_06]
            else if (wr_go && !s_axi_awready && s_axi_awaddr == ACAD_REG_RES) mcheck_abort <= 1'b0;
        end
    end

    // Read channel.
    logic [31:0] rd_mux;
    always_comb begin
        unique case (s_axi_araddr)
            ACAD_REG_CTRL:   rd_mux = {29'h0, xlate};
            ACAD_REG_ADDR_L: rd_mux = req_addr[31:0];
            ACAD_REG_ADDR_H: rd_mux = req_addr[63:32];
            ACAD_REG_CMD:    rd_mux = {24'h0, req_present, req_code, req_op};
            ACAD_REG_RES:    rd_mux = {12'h0, props, 1'b0, done, res[7:1], mcheck_abort};
            ACAD_REG_OUTL:   rd_mux = out_addr[31:0];
            ACAD_REG_OUTH:   rd_mux = out_addr[63:32];
            ACAD_REG_CFG:    rd_mux = {16'h0, 8'(TOP_VIRT_BIT_POS), 8'(TOP_PHYS_BIT_POS)};  // [RULE_08]
            default:         rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= ACAD_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= (s_axi_araddr <= ACAD_REG_CFG) ? ACAD_OKAY : ACAD_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence seq_cmd_bad_fetch;
        req_start && !addr_good && req_op inside {ACAD_OP_IFETCH, ACAD_OP_BRANCH};
    endsequence
    AST_FETCH_TRAP: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE_04]
        seq_cmd_bad_fetch |=> res.instr_trap) else $error("fetch trap missing");
    AST_DATA_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE_05]
        req_start && !addr_good && req_op == ACAD_OP_LOAD |=> res.data_fault)
        else $error("data fault missing");
    AST_SPEC_TOKEN: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE_16]
        req_start && req_op == ACAD_OP_SPEC_LD |=> res.token_bit == !$past(addr_good)
        && !res.data_fault) else $error("speculative token wrong");
    AST_RSV_CODE: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE_21]
        req_start && req_op == ACAD_OP_INSERT && va_good && !req_present
        && req_code inside {3'b001, 3'b010, 3'b011} |=> res.rsv_field_fault)
        else $error("reserved code not faulted");
    AST_PHYS_ATTR: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE_23]
        req_start && phys_mode |=> props.cacheable == !$past(req_addr[ACAD_ATTR_BIT])
        && out_addr[ACAD_ATTR_BIT] == 1'b0) else $error("physical attribute wrong");
    AST_MCHECK: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE_06]
        platform_timeout ##1 platform_timeout |-> ##2 mcheck_abort)
        else $error("machine check not raised");
    AST_OUT_SEXT: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE_18]
        req_start && req_op == ACAD_OP_GPURGE_O |=>
        out_addr[63] == $past(req_addr[TOP_VIRT_BIT_POS])) else $error("purge not extended");
    AST_UC_SEQ: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE_20]
        req_start && !phys_mode && req_code == ACAD_AC_EXPORT |=>
        props.sequential && props.exported && !props.speculative)
        else $error("exported uncached decode wrong");
endmodule : acad_core
`default_nettype wire

// File: bench/acad_platform_model.sv
// Platform model: signals a transaction time-out for an unpopulated range.
// Assumes the bench raises req while a reference to such a range is pending.
`default_nettype none
module acad_platform_model (
    input  wire logic aclk,             // Core clock.
    input  wire logic req,              // Pending unpopulated reference.
    output logic      platform_timeout  // Time-out level to the block.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] dly;
    // The platform answers three cycles late, so the pin is never instant.
    always_ff @(posedge aclk) begin
        dly              <= {dly[0], req};
        platform_timeout <= dly[1];
    end
endmodule : acad_platform_model
`default_nettype wire

// File: bench/acad_core_test.sv
// Table bench for the address check block, driven over AXI4-Lite.
// Assumes the platform model and a 40 ns core clock.
`default_nettype none
module acad_core_test;
    import acad_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] PB = 64'h0000_0200_0000_1000, VB = 64'h0008_0000_0000_1000;
    localparam logic [63:0] VG = 64'h7FFC_0000_0000_1000, PU = 64'h8000_0000_0000_1000;
    typedef struct packed {
        logic [2:0] c; logic [63:0] a; logic [7:0] m; logic [31:0] e, k;
    } acad_row_t;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, req = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd_v;
    logic awr, wr_r, bv, arr, rv, tmo, mck;
    logic [1:0] br, rr, rsp;
    logic [31:0] rdat;
    int error_cnt = 0, checks_done = 0;
    // Flag rows compare the outcome bits; decode rows compare the properties.
    acad_row_t rows [24] = '{
        '{0, PB, 8'h80, 32'h180, 32'h1FF}, '{0, PB, 8'h82, 32'h140, 32'h1FF},
        '{0, PU, 8'h82, 32'h100, 32'h1FF}, '{7, VB, 8'h82, 32'h140, 32'h1FF},
        '{7, VG, 8'h82, 32'h100, 32'h1FF}, '{7, VB, 8'h83, 32'h140, 32'h1FF},
        '{7, VB, 8'h84, 32'h140, 32'h1FF}, '{7, VB, 8'h85, 32'h108, 32'h1FF},
        '{7, VB, 8'h86, 32'h104, 32'h1FF}, '{7, VB, 8'h88, 32'h102, 32'h1FF},
        '{7, VB, 8'h89, 32'h108, 32'h1FF}, '{7, VB, 8'h81, 32'h180, 32'h1FF},
        '{7, VB, 8'h8B, 32'h140, 32'h1FF}, '{7, VB, 8'h80, 32'h180, 32'h1FF},
        '{7, VB, 8'h8A, 32'h140, 32'h1FF}, '{7, VG, 8'h2A, 32'h120, 32'h1FF},
        '{7, VG, 8'h8C, 32'h110, 32'h1FF}, '{7, VB, 8'h8F, 32'h140, 32'h1FF},
        '{7, VG, 8'h82, 32'hCA100, 32'hFFD00}, '{7, VG, 8'hC2, 32'h12100, 32'hFFD00},
        '{7, VG, 8'hD2, 32'h12900, 32'hFFD00}, '{7, VG, 8'hE2, 32'h28100, 32'hFFD00},
        '{0, 64'h1000, 8'h82, 32'hC4100, 32'hF4D00}, '{0, PU, 8'h82, 32'h10100, 32'hF4D00}};
    acad_core #(.TOP_PHYS_BIT_POS(40), .TOP_VIRT_BIT_POS(50)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .platform_timeout(tmo), .mcheck_abort(mck));
    acad_platform_model plat (.aclk(aclk), .req(req), .platform_timeout(tmo));
    initial begin
        forever #20 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Each channel is released at its own ready; the response ends the write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wr_r) wv <= 0;
        end while (bv !== 1'b1);
        rsp = br;
        bre <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        ara <= a; arv <= 1; rre <= 1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 0;
        end while (rv !== 1'b1);
        rd_v = rdat; rsp = rr;
        rre <= 0;
    endtask : rd
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // A hang costs one mismatch; the whole run needs well under 2000 cycles.
    initial begin
        #200us;
        error_cnt++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(8'h00); chk("ctrl reset", 32'h7, rd_v & 32'h7);
        rd(8'h1C); chk("cfg", 32'h3228, rd_v & 32'hFFFF);
        foreach (rows[i]) begin
            wr(8'h00, {29'h0, rows[i].c}); wr(8'h04, rows[i].a[31:0]);
            wr(8'h08, rows[i].a[63:32]); wr(8'h0C, {24'h0, rows[i].m});
            @(posedge aclk);
            rd(8'h10);
            chk($sformatf("row%0d", i), rows[i].e, rd_v & rows[i].k);
        end
        rd(8'h20); chk("unmapped", 32'h2, {30'h0, rsp} | rd_v);
        wr(8'h14, 32'h1); chk("ro write", 32'h2, {30'h0, rsp});
        // Outgoing global purge must sign-extend the top virtual bit.
        wr(8'h04, VG[31:0]); wr(8'h08, VG[63:32]); wr(8'h0C, 32'h8D);
        @(posedge aclk);
        rd(8'h18); chk("gpurge out", 32'hFFFC0000, rd_v);
        req <= 1;
        repeat (8) @(posedge aclk);
        chk("mcheck set", 32'h1, {31'h0, mck});
        req <= 0;
        repeat (8) @(posedge aclk);
        wr(8'h10, 32'h0); @(posedge aclk);
        chk("mcheck clr", 32'h0, {31'h0, mck});
        finish_test();
    end
endmodule : acad_core_test
`default_nettype wire
